// ---- hub_map.vh ----
// Register map, field positions and counts of the hub DMA engine
`ifndef HUB_MAP_VH
`define HUB_MAP_VH
`define HUB_NCH 24
`define HUB_NTD 128
`define HUB_STARVE_MAX 8
`define HUB_SPOKE_LSB 16
`define HUB_SPOKE_RSVD 3'h5
// Word addresses on the register port
`define HUB_A_GCTL 10'h000
`define HUB_A_GSTAT 10'h001
`define HUB_A_CCFG 2'h1
`define HUB_A_CSTAT 2'h2
`define HUB_A_TSRC 2'h1
`define HUB_A_TDST 2'h2
`define HUB_A_TCTL 2'h3
// Channel config fields
`define HUB_CF_EN 0
`define HUB_CF_PRIO 3:1
`define HUB_CF_HOL 4
`define HUB_CF_STALL 5
`define HUB_CF_CANCEL 6
`define HUB_CF_SWTRIG 7
`define HUB_CF_FIRST 14:8
`define HUB_CF_CHE 15
`define HUB_CF_TGT 20:16
// Descriptor control fields
`define HUB_TC_LEN 15:0
`define HUB_TC_NEXT 22:16
`define HUB_TC_END 23
`define HUB_TC_SIZE 25:24
`define HUB_TC_SINC 26
`define HUB_TC_DINC 27
`define HUB_TC_IA 28
`define HUB_TC_IB 29
`define HUB_TC_INF 30
`endif

// ---- hub_dma.v ----
// Peripheral hub DMA engine with CPU/DMA spoke arbiter
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "hub_map.vh"
// Functional notes
// R1: CPU and DMA engine are the two masters; both may start accesses.
// R2: Eight spokes from address bits; spoke 5 reserved, 0 SRAM, 2 local.
// R3: CPU granted in parallel with DMA when spokes differ.
// R4: Read of next element overlaps write of last on different spokes.
// R5: Element sizes of 8, 16, 24 and 32 bits.
// R6: Twenty-four channels sharing a pool of 128 descriptors.
// R7: Descriptors writable any time; chained through a next index.
// R8: Each channel has a three-bit priority, eight levels.
// R9: Start on trigger input edge, software trigger or chain completion.
// R10: Two interrupt pulses per channel: descriptor done and chain end.
// R11: Stall bit holds a channel; cancel bit drops and rewinds it.
// R12: Length 1 byte to 64 KB, or unbounded.
// R13: CPU wins a spoke that both masters want.
// R14: After a run of CPU wins the DMA takes one cycle.
// R15: Lowest priority number wins among requesting channels.
// R16: Higher priority channel takes the bus at the next element.
// R17: Element in flight finishes before switching channels.
// R18: Fairness slots give levels 2..7 shares of 50 down to 1.5 percent.
// R19: Levels 0 and 1 bypass fairness slots.
// R20: Equal priority channels rotate round robin.
// R21: Head of line bit takes a channel out of rotation.
// R22: Fairness off means pure priority order.
// R23: A 64 slot repeating schedule bounds the wait of levels 2..7.
module hub_dma #(
  parameter NCH = `HUB_NCH,
  parameter NTD = `HUB_NTD,
  parameter STARVE_MAX = `HUB_STARVE_MAX
) (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire [9:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  input wire [NCH-1:0] trig_i,
  input wire cpu_req_i,
  input wire [31:0] cpu_addr_i,
  output reg cpu_gnt_o,
  output reg rd_req_o,
  output reg [31:0] rd_addr_o,
  output reg [1:0] rd_size_o,
  input wire rd_ack_i,
  input wire [31:0] rd_data_i,
  output reg wr_req_o,
  output reg [31:0] wr_addr_o,
  output reg [31:0] wr_data_o,
  output reg [1:0] wr_size_o,
  input wire wr_ack_i,
  output reg [NCH-1:0] irq_desc_o,
  output reg [NCH-1:0] irq_chain_o
);

  localparam ST_ARB = 2'b01;
  localparam ST_RD = 2'b10;

  // Spoke number of an address
  function [2:0] spoke_of;
    input [31:0] a;
    begin
      spoke_of = a[`HUB_SPOKE_LSB+2:`HUB_SPOKE_LSB];
    end
  endfunction

  // Level favoured by a fairness slot, zero for a free slot
  function [2:0] slot_lvl;
    input [5:0] s;
    begin
      casez (s)
        6'b?????0: slot_lvl = 3'h2;
        6'b????01: slot_lvl = 3'h3;
        6'b???011: slot_lvl = 3'h4;
        6'b??0111: slot_lvl = 3'h5;
        6'b?01111: slot_lvl = 3'h6;
        6'b011111: slot_lvl = 3'h7;
        default: slot_lvl = 3'h0;
      endcase
    end
  endfunction

  reg [20:0] cfg_q [0:NCH-1];
  reg [6:0] cur_q [0:NCH-1];
  reg [16:0] done_q [0:NCH-1];
  reg [31:0] tsrc_q [0:NTD-1];
  reg [31:0] tdst_q [0:NTD-1];
  reg [30:0] tctl_q [0:NTD-1];
  reg [NCH-1:0] pend_q;
  reg [NCH-1:0] err_q;
  reg [NCH-1:0] trig_q;
  reg fair_q;
  reg [5:0] slot_q;
  reg [4:0] last_q;
  reg [4:0] ach_q;
  reg [1:0] st_q;
  reg [31:0] rdst_q;
  reg hold_v_q;
  reg [31:0] hold_d_q;
  reg [31:0] hold_a_q;
  reg [1:0] hold_s_q;
  reg [3:0] starve_q;

  // Arbiter scratch
  integer i;
  integer t;
  integer j;
  reg [NCH-1:0] elig;
  reg any;
  reg [2:0] best;
  reg [2:0] lvl;
  reg slot_hit;
  reg hol_hit;
  reg [4:0] win;

  // Pick the winning channel for the next element
  always @*
  begin
    elig = {NCH{1'b0}};
    any = 1'b0;
    best = 3'h7;
    slot_hit = 1'b0;
    hol_hit = 1'b0;
    win = 5'h0;
    t = 0;
    for (i = 0; i < NCH; i = i + 1)
    begin
      elig[i] = cfg_q[i][`HUB_CF_EN] & pend_q[i] &
                ~cfg_q[i][`HUB_CF_STALL] & ~err_q[i]; // [R11]
      if (elig[i] && (!any || cfg_q[i][`HUB_CF_PRIO] < best))
      begin
        best = cfg_q[i][`HUB_CF_PRIO]; // [R15] [R8]
        any = 1'b1;
      end
      if (elig[i] && cfg_q[i][`HUB_CF_PRIO] == slot_lvl(slot_q))
        slot_hit = 1'b1;
    end
    lvl = best; // [R22] [R19]
    if (fair_q && best >= 3'h2 && slot_hit)
      lvl = slot_lvl(slot_q); // [R18] [R23]
    // Round robin from the channel after the last one served
    for (i = NCH - 1; i >= 0; i = i - 1)
    begin
      t = last_q + 1 + i;
      if (t >= NCH)
        t = t - NCH;
      if (elig[t] && cfg_q[t][`HUB_CF_PRIO] == lvl)
        win = t[4:0]; // [R20]
    end
    // Head of line channels beat the rotation
    for (i = NCH - 1; i >= 0; i = i - 1)
    begin
      if (elig[i] && cfg_q[i][`HUB_CF_PRIO] == lvl &&
          cfg_q[i][`HUB_CF_HOL])
      begin
        hol_hit = 1'b1;
        win = i[4:0]; // [R21]
      end
    end
  end

  // Addresses of the winner's next element
  wire [6:0] w_desc = cur_q[win];
  wire [30:0] w_ctl = tctl_q[w_desc];
  wire [31:0] w_off = {15'h0, done_q[win]};
  wire [31:0] w_src = tsrc_q[w_desc] + (w_ctl[`HUB_TC_SINC] ? w_off : 32'h0);
  wire [31:0] w_dst = tdst_q[w_desc] + (w_ctl[`HUB_TC_DINC] ? w_off : 32'h0);
  wire [2:0] w_sp = spoke_of(w_src);
  wire [2:0] cpu_sp = spoke_of(cpu_addr_i);
  wire starve_hit = (starve_q == STARVE_MAX[3:0]);

  // Read issue: spoke checks against write side and CPU
  wire arb_ok = st_q[0] & any & ~hold_v_q;
  wire bad_sp = (w_sp == `HUB_SPOKE_RSVD) |
                (spoke_of(w_dst) == `HUB_SPOKE_RSVD); // [R2]
  wire rd_wr_clash = wr_req_o & (spoke_of(wr_addr_o) == w_sp); // [R4]
  wire rd_cpu_clash = cpu_req_i & (cpu_sp == w_sp) & ~starve_hit; // [R13]
  wire err_go = arb_ok & bad_sp;
  wire rd_go = arb_ok & ~bad_sp & ~rd_wr_clash & ~rd_cpu_clash;

  // Write issue from the holding register
  wire wr_cpu_clash = cpu_req_i & (cpu_sp == spoke_of(hold_a_q)) &
                      ~starve_hit; // [R13]
  wire wr_go = hold_v_q & ~wr_req_o & ~wr_cpu_clash;
  wire dma_blocked = (arb_ok & ~bad_sp & ~rd_wr_clash & rd_cpu_clash) |
                     (hold_v_q & ~wr_req_o & wr_cpu_clash);

  // Spokes held by the DMA in the next cycle
  wire rd_busy = st_q[1] | rd_go;
  wire [2:0] rd_sp = st_q[1] ? spoke_of(rd_addr_o) : w_sp;
  wire wr_busy = wr_req_o | wr_go;
  wire [2:0] wr_sp = wr_req_o ? spoke_of(wr_addr_o) : spoke_of(hold_a_q);
  wire cpu_gnt_d = cpu_req_i & ~(rd_busy & rd_sp == cpu_sp) &
                   ~(wr_busy & wr_sp == cpu_sp); // [R1] [R3]

  // Progress of the element just read
  wire upd = st_q[1] & rd_ack_i;
  wire [6:0] a_desc = cur_q[ach_q];
  wire [30:0] a_ctl = tctl_q[a_desc];
  wire [16:0] a_nd = done_q[ach_q] + {15'h0, a_ctl[`HUB_TC_SIZE]} + 17'h1;
  wire a_fin = ~a_ctl[`HUB_TC_INF] &
               (a_nd > {1'b0, a_ctl[`HUB_TC_LEN]}); // [R12]
  wire [20:0] a_cfg = cfg_q[ach_q];

  wire reg_ch_wr = reg_wr_i & reg_addr_i[9:6] == {2'h0, `HUB_A_CCFG} &
                   ~reg_addr_i[5] & reg_addr_i[4:0] < NCH;
  wire [4:0] r_ch = reg_addr_i[4:0];
  wire [NCH-1:0] trig_rise = trig_i & ~trig_q;

  // Descriptor pool, rewritable while channels use it
  always @(posedge core_clk_i)
  begin
    if (reg_wr_i && !reg_addr_i[7])
    begin
      case (reg_addr_i[9:8])
        `HUB_A_TSRC: tsrc_q[reg_addr_i[6:0]] <= reg_wdata_i; // [R7] [R6]
        `HUB_A_TDST: tdst_q[reg_addr_i[6:0]] <= reg_wdata_i;
        `HUB_A_TCTL: tctl_q[reg_addr_i[6:0]] <= reg_wdata_i[30:0];
        default: ;
      endcase
    end
  end

  // Channel state: triggers, progress, chaining, stall and cancel
  always @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      for (j = 0; j < NCH; j = j + 1)
      begin
        cfg_q[j] <= 21'h0;
        cur_q[j] <= 7'h0;
        done_q[j] <= 17'h0;
      end
      pend_q <= {NCH{1'b0}};
      err_q <= {NCH{1'b0}};
      trig_q <= {NCH{1'b0}};
      irq_desc_o <= {NCH{1'b0}};
      irq_chain_o <= {NCH{1'b0}};
      fair_q <= 1'b0;
    end
    else
    begin
      trig_q <= trig_i;
      irq_desc_o <= {NCH{1'b0}};
      irq_chain_o <= {NCH{1'b0}};
      if (err_go)
      begin
        err_q[win] <= 1'b1;
        pend_q[win] <= 1'b0;
      end
      if (upd)
      begin
        if (a_fin)
        begin
          irq_desc_o[ach_q] <= a_ctl[`HUB_TC_IA]; // [R10]
          done_q[ach_q] <= 17'h0;
          if (a_ctl[`HUB_TC_END])
          begin
            irq_chain_o[ach_q] <= a_ctl[`HUB_TC_IB]; // [R10]
            pend_q[ach_q] <= 1'b0;
            cur_q[ach_q] <= a_cfg[`HUB_CF_FIRST];
          end
          else
            cur_q[ach_q] <= a_ctl[`HUB_TC_NEXT]; // [R7]
        end
        else
          done_q[ach_q] <= a_nd;
      end
      if (reg_wr_i && reg_addr_i == `HUB_A_GCTL)
        fair_q <= reg_wdata_i[0];
      if (reg_ch_wr)
      begin
        cfg_q[r_ch] <= {reg_wdata_i[20:8], 2'b00, reg_wdata_i[5:0]};
        if (reg_wdata_i[`HUB_CF_CANCEL])
        begin
          pend_q[r_ch] <= 1'b0; // [R11]
          err_q[r_ch] <= err_go & (win == r_ch); // Set wins
          done_q[r_ch] <= 17'h0;
          cur_q[r_ch] <= reg_wdata_i[`HUB_CF_FIRST];
        end
      end
      // Triggers last so a set beats any clear
      for (j = 0; j < NCH; j = j + 1)
      begin
        if (trig_rise[j])
          pend_q[j] <= 1'b1; // [R9]
      end
      if (reg_ch_wr && reg_wdata_i[`HUB_CF_SWTRIG])
        pend_q[r_ch] <= 1'b1; // [R9]
      if (upd && a_fin && a_ctl[`HUB_TC_END] && a_cfg[`HUB_CF_CHE] &&
          a_cfg[`HUB_CF_TGT] < NCH)
        pend_q[a_cfg[`HUB_CF_TGT]] <= 1'b1; // [R9]
    end
  end

  // Read and write engines, CPU grant and fairness slot
  always @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_q <= ST_ARB;
      rd_req_o <= 1'b0;
      rd_addr_o <= 32'h0;
      rd_size_o <= 2'h0;
      rdst_q <= 32'h0;
      ach_q <= 5'h0;
      last_q <= 5'h0;
      slot_q <= 6'h0;
      hold_v_q <= 1'b0;
      hold_d_q <= 32'h0;
      hold_a_q <= 32'h0;
      hold_s_q <= 2'h0;
      wr_req_o <= 1'b0;
      wr_addr_o <= 32'h0;
      wr_data_o <= 32'h0;
      wr_size_o <= 2'h0;
      starve_q <= 4'h0;
      cpu_gnt_o <= 1'b0;
    end
    else
    begin
      cpu_gnt_o <= cpu_gnt_d;
      // Count cycles the CPU keeps the DMA off its spoke
      if (rd_go || wr_go)
        starve_q <= 4'h0;
      else if (dma_blocked && !starve_hit)
        starve_q <= starve_q + 4'h1; // [R14]
      case (st_q)
        ST_ARB:
        begin
          if (rd_go)
          begin
            st_q <= ST_RD;
            rd_req_o <= 1'b1;
            rd_addr_o <= w_src;
            rd_size_o <= w_ctl[`HUB_TC_SIZE]; // [R5]
            rdst_q <= w_dst;
            ach_q <= win; // [R16]
            if (!hol_hit)
              last_q <= win;
            if (fair_q && cfg_q[win][`HUB_CF_PRIO] >= 3'h2)
              slot_q <= slot_q + 6'h1; // [R23]
          end
        end
        ST_RD:
        begin
          // Element in flight always completes
          if (rd_ack_i)
          begin
            st_q <= ST_ARB; // [R17]
            rd_req_o <= 1'b0;
            hold_v_q <= 1'b1;
            hold_d_q <= rd_data_i;
            hold_a_q <= rdst_q;
            hold_s_q <= rd_size_o;
          end
        end
        default: st_q <= ST_ARB;
      endcase
      // Write side drains the holding register
      if (wr_go)
      begin
        hold_v_q <= 1'b0; // [R4]
        wr_req_o <= 1'b1;
        wr_addr_o <= hold_a_q;
        wr_data_o <= hold_d_q;
        wr_size_o <= hold_s_q;
      end
      else if (wr_req_o && wr_ack_i)
        wr_req_o <= 1'b0;
    end
  end

  // Register read port, data in the following cycle only
  always @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 32'h0;
    else if (!reg_rd_i)
      reg_rdata_o <= 32'h0;
    else if (reg_addr_i[9:8] != 2'h0)
    begin
      if (reg_addr_i[7])
        reg_rdata_o <= 32'h0;
      else if (reg_addr_i[9:8] == `HUB_A_TSRC)
        reg_rdata_o <= tsrc_q[reg_addr_i[6:0]];
      else if (reg_addr_i[9:8] == `HUB_A_TDST)
        reg_rdata_o <= tdst_q[reg_addr_i[6:0]];
      else
        reg_rdata_o <= {1'b0, tctl_q[reg_addr_i[6:0]]};
    end
    else if (reg_addr_i == `HUB_A_GCTL)
      reg_rdata_o <= {31'h0, fair_q};
    else if (reg_addr_i == `HUB_A_GSTAT)
      reg_rdata_o <= {13'h0, slot_q, ach_q, wr_req_o, hold_v_q,
                      any, st_q[1], starve_q};
    else if (reg_addr_i[5] || reg_addr_i[4:0] >= NCH)
      reg_rdata_o <= 32'h0;
    else if (reg_addr_i[7:6] == `HUB_A_CCFG)
      reg_rdata_o <= {11'h0, cfg_q[r_ch]};
    else if (reg_addr_i[7:6] == `HUB_A_CSTAT)
      reg_rdata_o <= {6'h0, done_q[r_ch], cur_q[r_ch], err_q[r_ch],
                      pend_q[r_ch]};
    else
      reg_rdata_o <= 32'h0;
  end

endmodule // hub_dma

// ---- dpha_asserts.sv ----
// Port assertions for the hub DMA engine
`timescale 1ns/1ps
module dpha_asserts #(
  parameter NCH = 24
) (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire reg_rd_i,
  input wire [31:0] reg_rdata_o,
  input wire cpu_req_i,
  input wire [31:0] cpu_addr_i,
  input wire cpu_gnt_o,
  input wire rd_req_o,
  input wire [31:0] rd_addr_o,
  input wire [1:0] rd_size_o,
  input wire rd_ack_i,
  input wire wr_req_o,
  input wire [31:0] wr_addr_o,
  input wire wr_ack_i,
  input wire [NCH-1:0] irq_desc_o,
  input wire [NCH-1:0] irq_chain_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Link phases
  sequence s_rd_wait; rd_req_o && !rd_ack_i; endsequence
  sequence s_wr_wait; wr_req_o && !wr_ack_i; endsequence
  sequence s_rd_done; rd_req_o && rd_ack_i; endsequence
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("Read data not idle");
  a_rd_hold: assert property (s_rd_wait |=> rd_req_o && $stable(rd_addr_o)
    && $stable(rd_size_o)) else $error("Read request not held");
  a_wr_hold: assert property (s_wr_wait |=> wr_req_o && $stable(wr_addr_o))
    else $error("Write request not held");
  a_rd_drop: assert property (s_rd_done |=> !rd_req_o)
    else $error("Read request after ack");
  a_cpu_blocked: assert property (s_rd_wait and cpu_req_i
    && rd_addr_o[18:16] == cpu_addr_i[18:16] |=> !cpu_gnt_o)
    else $error("CPU granted a held spoke");
  a_cpu_idle: assert property (!cpu_req_i |=> !cpu_gnt_o)
    else $error("CPU grant without request");
  a_no_rsvd: assert property ((!rd_req_o || rd_addr_o[18:16] != 3'h5) &&
    (!wr_req_o || wr_addr_o[18:16] != 3'h5)) else $error("Reserved spoke used");
  a_irq_cause: assert property ((irq_desc_o | irq_chain_o) != 0
    |-> $past(rd_ack_i)) else $error("Interrupt without read ack");
  a_irq_pulse: assert property (irq_chain_o != 0
    |=> (irq_chain_o & $past(irq_chain_o)) == 0) else $error("Long pulse");
endmodule // dpha_asserts

// ---- dpha_bus_model.sv ----
// Spoke memory answering the DMA read and write links
`timescale 1ns/1ps
module dpha_bus_model (
  input wire clk_i,
  input wire rst_i,
  input wire [1:0] dly_i,
  input wire rd_req_i,
  input wire [31:0] rd_addr_i,
  output reg rd_ack_o,
  output reg [31:0] rd_data_o,
  input wire wr_req_i,
  input wire [31:0] wr_addr_i,
  input wire [31:0] wr_data_i,
  input wire [1:0] wr_size_i,
  output reg wr_ack_o
);
  reg [7:0] mem [0:4095];
  reg [1:0] rc;
  reg [1:0] wc;
  wire [11:0] ra = rd_addr_i[11:0];
  wire [11:0] wa = wr_addr_i[11:0];
  integer k;
  // Read side: ack after a wait, data toggles when not answering
  always @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      rd_ack_o <= 1'b0;
      rc <= 2'h0;
      rd_data_o <= 32'h0;
    end
    else
    begin
      rd_ack_o <= 1'b0;
      rd_data_o <= ~rd_data_o;
      if (rd_req_i && !rd_ack_o && rc >= dly_i)
      begin
        rd_ack_o <= 1'b1;
        rc <= 2'h0;
        rd_data_o <= {mem[ra+12'h3], mem[ra+12'h2], mem[ra+12'h1], mem[ra]};
      end
      else if (rd_req_i && !rd_ack_o)
        rc <= rc + 2'h1;
    end
  // Write side: stores size plus one bytes at ack
  always @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      wr_ack_o <= 1'b0;
      wc <= 2'h0;
    end
    else
    begin
      wr_ack_o <= 1'b0;
      if (wr_req_i && !wr_ack_o && wc >= dly_i)
      begin
        wr_ack_o <= 1'b1;
        wc <= 2'h0;
        for (k = 0; k < 4; k = k + 1)
          if (k <= wr_size_i)
            mem[wa+k] <= wr_data_i[8*k+:8];
      end
      else if (wr_req_i && !wr_ack_o)
        wc <= wc + 2'h1;
    end
endmodule // dpha_bus_model

// ---- test_dma_peripheral_hub_arbiter.sv ----
// Self-checking bench for the hub DMA engine
`timescale 1ns/1ps
module test_dma_peripheral_hub_arbiter;
  reg core_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, cpu_req_i;
  reg [9:0] reg_addr_i;
  reg [31:0] reg_wdata_i, cpu_addr_i, got;
  reg [23:0] trig_i;
  reg [7:0] r = 8'h5c;
  reg [1:0] dly;
  wire [31:0] reg_rdata_o, rd_addr_o, rd_data_i, wr_addr_o, wr_data_o;
  wire [1:0] rd_size_o, wr_size_o;
  wire [23:0] irq_desc_o, irq_chain_o;
  wire cpu_gnt_o, rd_req_o, rd_ack_i, wr_req_o, wr_ack_i;
  integer fail_count, samples_checked, s, i, n;
  hub_dma dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .trig_i(trig_i),
    .cpu_req_i(cpu_req_i), .cpu_addr_i(cpu_addr_i), .cpu_gnt_o(cpu_gnt_o),
    .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o), .rd_size_o(rd_size_o),
    .rd_ack_i(rd_ack_i), .rd_data_i(rd_data_i), .wr_req_o(wr_req_o),
    .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_size_o(wr_size_o),
    .wr_ack_i(wr_ack_i), .irq_desc_o(irq_desc_o), .irq_chain_o(irq_chain_o));
  dpha_bus_model peer (.clk_i(core_clk_i), .rst_i(sys_rst_i), .dly_i(dly),
    .rd_req_i(rd_req_o), .rd_addr_i(rd_addr_o), .rd_ack_o(rd_ack_i),
    .rd_data_o(rd_data_i), .wr_req_i(wr_req_o), .wr_addr_i(wr_addr_o),
    .wr_data_i(wr_data_o), .wr_size_i(wr_size_o), .wr_ack_o(wr_ack_i));
  function [7:0] lfsr(input [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  // Random CPU traffic and peer delay
  always @(posedge core_clk_i)
  begin
    r <= lfsr(r);
    cpu_req_i <= r[0] & r[6];
    cpu_addr_i <= {13'h0, r[3:1], 16'h0};
    dly <= r[5:4];
  end
  task chk(input [31:0] g, input [31:0] e);
  begin
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
      fail_count = fail_count + 1;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  end
  endtask
  task results;
  begin
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  task wreg(input [9:0] a, input [31:0] d);
  begin
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  end
  endtask
  task rreg(input [9:0] a);
  begin
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 got = reg_rdata_o;
  end
  endtask
  // Descriptor with both interrupts, end of chain; cancel loads first one
  task setup(input [4:0] ch, input [6:0] di, input [31:0] sa, input [31:0] da,
    input [1:0] sz, input [15:0] len, input [2:0] pr);
  begin
    wreg(10'h100 + di, sa);
    wreg(10'h200 + di, da);
    wreg(10'h300 + di, {2'h0, 4'hf, sz, 1'b1, di, len - 16'h1});
    wreg(10'h040 + ch, {17'h0, di, 4'h4, pr, 1'b1});
  end
  endtask
  task fire(input [23:0] m);
  begin
    @(posedge core_clk_i);
    trig_i <= m;
    @(posedge core_clk_i);
    trig_i <= 24'h0;
  end
  endtask
  task wait_irq(input [4:0] ch);
  begin
    n = 0;
    while (irq_chain_o[ch] !== 1'b1 && n < 3000)
    begin
      @(negedge core_clk_i);
      n = n + 1;
    end
    if (n == 3000)
    begin
      fail_count = fail_count + 1;
      results;
    end
  end
  endtask
  // Main sequence
  initial
  begin
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = 0;
    {trig_i, fail_count, samples_checked} = 0;
    sys_rst_i = 1'b1;
    repeat (20) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    wreg(10'h000, 32'h1);
    rreg(10'h000);
    chk(got & 32'h1, 32'h1);
    wreg(10'h000, 32'h0);
    rreg(10'h000);
    chk(got, 32'h0);
    rreg(10'h180);
    chk(got, 32'h0);
    // One copy per element size, spoke 0 to spoke 1
    for (s = 0; s < 4; s = s + 1)
    begin
      for (i = 0; i < 12; i = i + 1)
        peer.mem[s*64+i] = lfsr(i * 7 + s + 1);
      setup(5'h0, s[6:0], s * 64, 32'h10800 + s * 64, s[1:0], 3 * s + 3, 3'h4);
      fire(24'h1);
      wait_irq(5'h0);
      chk(irq_desc_o[0], 1);
      // Last element is still on the write link after the pulse
      repeat (20) @(posedge core_clk_i);
      for (i = 0; i < 3 * s + 3; i = i + 1)
        chk(peer.mem[2048+s*64+i], peer.mem[s*64+i]);
    end
    // Two channels at once: lower priority number wins
    setup(5'h1, 7'h10, 32'h200, 32'h10a00, 2'h0, 16'h4, 3'h3);
    setup(5'h2, 7'h11, 32'h300, 32'h10b00, 2'h0, 16'h4, 3'h0);
    fire(24'h6);
    n = 0;
    while (rd_req_o !== 1'b1 && n < 100)
    begin
      @(negedge core_clk_i);
      n = n + 1;
    end
    if (n == 100)
    begin
      fail_count = fail_count + 1;
      results;
    end
    chk(rd_addr_o, 32'h300);
    wait_irq(5'h2);
    wait_irq(5'h1);
    // Reserved spoke sets error, cancel clears it
    setup(5'h3, 7'h20, 32'h0, 32'h50000, 2'h0, 16'h1, 3'h2);
    fire(24'h8);
    repeat (20) @(posedge core_clk_i);
    rreg(10'h083);
    chk(got[1], 1);
    wreg(10'h043, {17'h0, 7'h20, 4'h4, 3'h2, 1'b1});
    rreg(10'h083);
    chk(got[1], 0);
    results;
  end
endmodule // test_dma_peripheral_hub_arbiter
bind hub_dma dpha_asserts #(.NCH(NCH)) u_chk (.core_clk_i(core_clk_i),
  .sys_rst_i(sys_rst_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .cpu_req_i(cpu_req_i), .cpu_addr_i(cpu_addr_i), .cpu_gnt_o(cpu_gnt_o),
  .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o), .rd_size_o(rd_size_o),
  .rd_ack_i(rd_ack_i), .wr_req_o(wr_req_o), .wr_addr_o(wr_addr_o),
  .wr_ack_i(wr_ack_i), .irq_desc_o(irq_desc_o), .irq_chain_o(irq_chain_o));
